/* core/flsq_map.vh */
/*
  Constants for the fault code lamp sequencer: fault indices, code digits,
  latch classes, response levels and default timing.
  Assumes inclusion by bare name from the core files.
*/
`ifndef FLSQ_MAP_VH
`define FLSQ_MAP_VH

// Number of fault classes and index width
`define FLSQ_NFAULT 20
`define FLSQ_IDXW 5

// Fault indices; lower index is higher default priority
`define FLSQ_F_THERMAL 5'h00
`define FLSQ_F_THROTTLE 5'h01
`define FLSQ_F_SPEEDPOT 5'h02
`define FLSQ_F_UNDERV 5'h03
`define FLSQ_F_OVERV 5'h04
`define FLSQ_F_MAIN_OFF 5'h05
`define FLSQ_F_EMR_ORDER 5'h06
`define FLSQ_F_MAIN 5'h07
`define FLSQ_F_MAIN_ON 5'h08
`define FLSQ_F_PUMP_ORDER 5'h09
`define FLSQ_F_WIRING 5'h0A
`define FLSQ_F_BRAKE_ON 5'h0B
`define FLSQ_F_PRECHARGE 5'h0C
`define FLSQ_F_BRAKE_OFF 5'h0D
`define FLSQ_F_HIPEDAL 5'h0E
`define FLSQ_F_CUR_SENSE 5'h0F
`define FLSQ_F_FAILSAFE 5'h10
`define FLSQ_F_NVM 5'h11
`define FLSQ_F_MOTOR_OPEN 5'h12
`define FLSQ_F_BATT_DISC 5'h13

// Faults cleared only by key cycle
`define FLSQ_KEY_LATCH_MASK 20'h99480
// Fault cleared by parameter change plus key cycle
`define FLSQ_NVM_MASK 20'h20000

// Digits: 5 per tens group, digits 1..5
`define FLSQ_DIGITS_PER_GROUP 5

// Safe response levels
`define FLSQ_RESP_NONE 2'h0
`define FLSQ_RESP_LIMIT 2'h1
`define FLSQ_RESP_CUTBACK 2'h2
`define FLSQ_RESP_DISABLE 2'h3
// Per fault: 1 = full drive disable (bit per fault index)
`define FLSQ_DISABLE_MASK 20'hBFDA0
// Per fault: 1 = current limit only (thermal, voltage)
`define FLSQ_LIMIT_MASK 20'h00019

// Default lamp timing, in ms, and clock rate
`define FLSQ_CLK_MHZ 250
`define FLSQ_PULSE_ON_MS 250
`define FLSQ_PULSE_OFF_MS 250
`define FLSQ_DIGIT_GAP_MS 750
`define FLSQ_CODE_GAP_MS 2000

`endif

/* core/flsq_hist_mem.v */
/*
  Fault history store: one flag per fault class, read through a registered
  port. Assumes single clock, async active-high reset.
*/
`timescale 1ns/100ps
module flsq_hist_mem #(
  parameter N = 20,
  parameter AW = 5
) (
  input wire clk_i,              // system clock
  input wire rst_i,              // async reset, active high
  input wire [N-1:0] set_i,      // faults occurring this cycle
  input wire clear_i,            // empty the list
  input wire [AW-1:0] rd_addr_i, // entry to read
  output reg rd_data_o,          // registered entry value
  output reg [N-1:0] all_o       // whole list, registered
);
  reg [N-1:0] store;
  genvar g;

  ////////////////////////////////////////////////////////////////////////
  generate
    for (g = 0; g < N; g = g + 1) begin : g_ent
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          store[g] <= 1'b0;
        end else if (set_i[g]) begin
          // New fault beats a simultaneous clear
          store[g] <= 1'b1;
        end else if (clear_i) begin
          store[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 1'b0;
      all_o <= {N{1'b0}};
    end else begin
      rd_data_o <= (rd_addr_i < N) ? store[rd_addr_i] : 1'b0;
      all_o <= store;
    end
  end
endmodule // flsq_hist_mem

/* core/flsq_pick.v */
/*
  Priority picker: selects the active fault with the best rank.
  Rank table is flat, RW bits per fault; lower rank wins, ties to lower
  index. Purely combinational; caller registers the result.
*/
`timescale 1ns/100ps
module flsq_pick #(
  parameter N = 20,
  parameter AW = 5,
  parameter RW = 5
) (
  input wire [N-1:0] act_i,      // active faults
  input wire [N*RW-1:0] rank_i,  // rank per fault
  output reg any_o,              // some fault active
  output reg [AW-1:0] idx_o      // chosen fault index
);
  integer i;
  reg [RW-1:0] best;
  reg [RW-1:0] r;

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    any_o = 1'b0;
    idx_o = {AW{1'b0}};
    best = {RW{1'b1}};
    r = {RW{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      r = rank_i[i*RW +: RW];
      if (act_i[i] && (!any_o || r < best)) begin
        any_o = 1'b1;
        best = r;
        idx_o = i[AW-1:0];
      end
    end
  end
endmodule // flsq_pick

/* core/flsq_seq.v */
/*
  Fault code lamp sequencer top. Collects fault conditions, applies the
  latching classes, picks the top fault, blinks its two digit code on the
  status lamp and keeps a fault history for the programming tool.
  Assumes fault conditions and key switch are synchronous to ref_clk_i.
*/
`timescale 1ns/100ps
`include "flsq_map.vh"
module flsq_seq #(
  parameter N = `FLSQ_NFAULT,
  parameter AW = `FLSQ_IDXW,
  parameter RW = 5,
  parameter TW = 32,
  parameter PULSE_ON_CYC = `FLSQ_PULSE_ON_MS * `FLSQ_CLK_MHZ * 1000,
  parameter PULSE_OFF_CYC = `FLSQ_PULSE_OFF_MS * `FLSQ_CLK_MHZ * 1000,
  parameter DIGIT_GAP_CYC = `FLSQ_DIGIT_GAP_MS * `FLSQ_CLK_MHZ * 1000,
  parameter CODE_GAP_CYC = `FLSQ_CODE_GAP_MS * `FLSQ_CLK_MHZ * 1000
) (
  input wire ref_clk_i,            // system clock, 250 MHz
  input wire rst_i,                // async reset, active high
  input wire [N-1:0] fault_cond_i, // fault conditions by index
  input wire key_on_i,             // key switch level
  input wire param_changed_i,      // pulse: tool changed a parameter
  input wire hist_clear_i,         // pulse: tool empties history
  input wire [AW-1:0] hist_addr_i, // history entry to read
  input wire rank_override_i,      // use rank table, not fixed order
  input wire [N*RW-1:0] rank_tbl_i,// rank per fault, lower wins
  input wire [TW-1:0] pulse_on_i,  // lamp on time, cycles, 0=default
  input wire [TW-1:0] pulse_off_i, // lamp off between pulses, 0=default
  input wire [TW-1:0] digit_gap_i, // gap between digits, 0=default
  input wire [TW-1:0] code_gap_i,  // gap after code, 0=default
  output reg lamp_o,               // status lamp, high = lit
  output reg fault_any_o,          // some fault reported
  output reg [AW-1:0] fault_idx_o, // shown fault index
  output reg [2:0] code_hi_o,      // first digit shown
  output reg [2:0] code_lo_o,      // second digit shown
  output reg [N-1:0] active_o,     // reported faults
  output reg [1:0] response_o,     // safe response level
  output reg hist_rd_o,            // history entry read value
  output reg [N-1:0] hist_all_o    // full history list
);
  // Sequencer states, one hot
  localparam [4:0] S_STEADY = 5'h01;
  localparam [4:0] S_ON1 = 5'h02;
  localparam [4:0] S_OFF1 = 5'h04;
  localparam [4:0] S_ON2 = 5'h08;
  localparam [4:0] S_OFF2 = 5'h10;
  // Codes per first digit
  localparam [AW-1:0] DPG = `FLSQ_DIGITS_PER_GROUP;

  reg [N-1:0] latched;
  reg [N-1:0] cond_q;
  reg key_q;
  reg nvm_armed;
  reg [4:0] state;
  reg [4:0] next_state;
  reg [TW-1:0] timer;
  reg [TW-1:0] next_timer;
  reg [2:0] pcnt;
  reg [2:0] next_pcnt;
  reg [AW-1:0] show_idx;
  reg [AW-1:0] next_show_idx;
  reg [2:0] cur_hi;
  reg [2:0] cur_lo;
  reg [2:0] next_hi;
  reg [2:0] next_lo;
  reg [AW-1:0] cur_grp;
  reg [AW-1:0] cur_pos;
  reg [AW-1:0] next_grp;
  reg [AW-1:0] next_pos;
  reg [N*RW-1:0] rank_eff;
  reg [1:0] next_resp;
  reg [N-1:0] hist_set;
  wire [N-1:0] active;
  wire pick_any;
  wire [AW-1:0] pick_idx;
  wire hist_rd;
  wire [N-1:0] hist_all;
  wire key_rise;
  wire [TW-1:0] t_on;
  wire [TW-1:0] t_off;
  wire [TW-1:0] t_dg;
  wire [TW-1:0] t_cg;
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // Fault classes
  assign key_rise = key_on_i & ~key_q;
  // live faults follow condition
  // Latch classes pass straight through too, so an onset shows at once
  assign active = fault_cond_i | latched;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latched <= {N{1'b0}};
      // Idle high, so leaving reset is no key cycle
      key_q <= 1'b1;
      nvm_armed <= 1'b0;
      cond_q <= {N{1'b0}};
    end else begin
      key_q <= key_on_i;
      cond_q <= fault_cond_i;
      if (param_changed_i) begin
        nvm_armed <= 1'b1;
      end else if (key_rise) begin
        nvm_armed <= 1'b0;
      end
      // key cycle clears key latches, and the NVM latch only if armed
      // New condition wins over the clearing key edge
      if (key_rise) begin
        latched <= (fault_cond_i & `FLSQ_KEY_LATCH_MASK)
                 | (nvm_armed ? (fault_cond_i & `FLSQ_NVM_MASK)
                              : (latched & `FLSQ_NVM_MASK))
                 | (fault_cond_i & `FLSQ_NVM_MASK);
      end else begin
        latched <= latched
                 | (fault_cond_i & (`FLSQ_KEY_LATCH_MASK | `FLSQ_NVM_MASK));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Priority
  always @* begin
    rank_eff = {N*RW{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      rank_eff[i*RW +: RW] = rank_override_i ? rank_tbl_i[i*RW +: RW]
                                             : i[RW-1:0];
    end
  end

  flsq_pick #(.N(N), .AW(AW), .RW(RW)) u_pick (
    .act_i(active),
    .rank_i(rank_eff),
    .any_o(pick_any),
    .idx_o(pick_idx)
  );

  // digit encoding
  // Digits of the index in play, for the pulse counting
  always @* begin
    cur_grp = show_idx / DPG;
    cur_pos = show_idx % DPG;
    cur_hi = 3'h1 + cur_grp[2:0];
    cur_lo = 3'h1 + cur_pos[2:0];
  end

  // digits shown
  // Taken from the next index, so the digit outputs never lag the
  // shown index by a cycle when a code starts
  always @* begin
    next_grp = next_show_idx / DPG;
    next_pos = next_show_idx % DPG;
    next_hi = 3'h1 + next_grp[2:0];
    next_lo = 3'h1 + next_pos[2:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Safe response
  always @* begin
    next_resp = `FLSQ_RESP_NONE;
    if ((active & `FLSQ_DISABLE_MASK) != {N{1'b0}}) begin
      next_resp = `FLSQ_RESP_DISABLE;
    end else if ((active & ~`FLSQ_LIMIT_MASK) != {N{1'b0}}) begin
      next_resp = `FLSQ_RESP_CUTBACK;
    end else if (active != {N{1'b0}}) begin
      next_resp = `FLSQ_RESP_LIMIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // History
  always @* begin
    hist_set = fault_cond_i & ~cond_q;
  end

  flsq_hist_mem #(.N(N), .AW(AW)) u_hist (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .set_i(hist_set),
    .clear_i(hist_clear_i),
    .rd_addr_i(hist_addr_i),
    .rd_data_o(hist_rd),
    .all_o(hist_all)
  );

  ////////////////////////////////////////////////////////////////////////
  // Blink sequencer
  assign t_on = (pulse_on_i != {TW{1'b0}}) ? pulse_on_i : PULSE_ON_CYC;
  assign t_off = (pulse_off_i != {TW{1'b0}}) ? pulse_off_i : PULSE_OFF_CYC;
  assign t_dg = (digit_gap_i != {TW{1'b0}}) ? digit_gap_i : DIGIT_GAP_CYC;
  assign t_cg = (code_gap_i != {TW{1'b0}}) ? code_gap_i : CODE_GAP_CYC;

  always @* begin
    next_state = state;
    next_timer = timer;
    next_pcnt = pcnt;
    next_show_idx = show_idx;
    case (state)
      S_STEADY: begin
        if (pick_any) begin
          next_show_idx = pick_idx;
          next_state = S_ON1;
          next_timer = t_on - 1'b1;
          next_pcnt = 3'h1;
        end
      end
      default: begin
        if (!active[show_idx]) begin
          next_state = S_STEADY;
        end else if (timer != {TW{1'b0}}) begin
          next_timer = timer - 1'b1;
        end else begin
          case (state)
            S_ON1: begin
              next_state = S_OFF1;
              next_timer = (pcnt == cur_hi) ? t_dg - 1'b1 : t_off - 1'b1;
            end
            S_OFF1: begin
              next_state = (pcnt == cur_hi) ? S_ON2 : S_ON1;
              next_pcnt = (pcnt == cur_hi) ? 3'h1 : pcnt + 3'h1;
              next_timer = t_on - 1'b1;
            end
            S_ON2: begin
              next_state = S_OFF2;
              next_timer = (pcnt == cur_lo) ? t_cg - 1'b1 : t_off - 1'b1;
            end
            S_OFF2: begin
              next_timer = t_on - 1'b1;
              if (pcnt == cur_lo) begin
                // Re-pick only between codes, so a code never splits
                next_state = S_ON1;
                next_pcnt = 3'h1;
                next_show_idx = pick_idx;
              end else begin
                next_state = S_ON2;
                next_pcnt = pcnt + 3'h1;
              end
            end
            default: begin
              next_state = S_STEADY;
            end
          endcase
        end
      end
    endcase
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_STEADY;
      timer <= {TW{1'b0}};
      pcnt <= 3'h1;
      show_idx <= {AW{1'b0}};
      lamp_o <= 1'b0;
      fault_any_o <= 1'b0;
      fault_idx_o <= {AW{1'b0}};
      code_hi_o <= 3'h0;
      code_lo_o <= 3'h0;
      active_o <= {N{1'b0}};
      response_o <= `FLSQ_RESP_NONE;
      hist_rd_o <= 1'b0;
      hist_all_o <= {N{1'b0}};
    end else begin
      state <= next_state;
      timer <= next_timer;
      pcnt <= next_pcnt;
      show_idx <= next_show_idx;
      lamp_o <= (next_state == S_STEADY) | (next_state == S_ON1)
              | (next_state == S_ON2);
      fault_any_o <= (next_state != S_STEADY);
      fault_idx_o <= next_show_idx;
      code_hi_o <= (next_state == S_STEADY) ? 3'h0 : next_hi;
      code_lo_o <= (next_state == S_STEADY) ? 3'h0 : next_lo;
      active_o <= active;
      response_o <= next_resp;
      hist_rd_o <= hist_rd;
      hist_all_o <= hist_all;
    end
  end
endmodule // flsq_seq

/* bench/flsq_seq_checker.sv */
/* Assertions on the lamp sequencer top ports.
   Assumes a bind from the bench top and a single clock domain. */
`timescale 1ns/100ps
module flsq_seq_checker #(
  parameter N = 20,
  parameter AW = 5,
  parameter RW = 5,
  parameter TW = 32
) (
  input wire ref_clk_i, // clock
  input wire rst_i, // reset
  input wire [N-1:0] fault_cond_i, // conditions
  input wire key_on_i, // key
  input wire param_changed_i, // tool write
  input wire hist_clear_i, // tool clear
  input wire [AW-1:0] hist_addr_i, // read index
  input wire rank_override_i, // rank select
  input wire [N*RW-1:0] rank_tbl_i, // ranks
  input wire [TW-1:0] pulse_on_i, // on time
  input wire [TW-1:0] pulse_off_i, // off time
  input wire [TW-1:0] digit_gap_i, // digit gap
  input wire [TW-1:0] code_gap_i, // code gap
  input wire lamp_o, // lamp
  input wire fault_any_o, // showing
  input wire [AW-1:0] fault_idx_o, // shown index
  input wire [2:0] code_hi_o, // digit one
  input wire [2:0] code_lo_o, // digit two
  input wire [N-1:0] active_o, // reported
  input wire [1:0] response_o, // response
  input wire hist_rd_o, // entry
  input wire [N-1:0] hist_all_o // list
);
  localparam [19:0] KEYM = 20'h99480;
  localparam [19:0] DISM = 20'hBFDA0;
  reg up;
  reg [N-1:0] prev_cond;
  reg [N-1:0] prev_act;
  reg [AW-1:0] idx_q;
  reg [TW-1:0] on_cnt;
  reg [TW-1:0] off_cnt;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      up <= 1'b0;
      prev_cond <= '0;
      prev_act <= '0;
      idx_q <= '0;
      on_cnt <= '0;
      off_cnt <= '0;
    end else begin
      up <= 1'b1;
      prev_cond <= fault_cond_i;
      prev_act <= active_o;
      idx_q <= fault_idx_o;
      // A new code restarts the run count
      on_cnt <= !(lamp_o && fault_any_o) ? '0 :
        (fault_idx_o != idx_q) ? TW'(1) : on_cnt + TW'(1);
      off_cnt <= lamp_o ? '0 : off_cnt + TW'(1);
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_pulse_end;
    $fell(lamp_o) && fault_any_o;
  endsequence
  sequence s_lamp_back;
    $rose(lamp_o) && fault_any_o && $stable(fault_idx_o) && $past(up);
  endsequence
  a_steady_lamp: assert property (up && !fault_any_o |-> lamp_o)
    else $error("lamp not steady without fault");
  a_idle_digits: assert property (up && !fault_any_o |->
    code_hi_o == 3'h0 && code_lo_o == 3'h0) else $error("digits while idle");
  a_dark_bounded: assert property (up && !lamp_o |-> fault_any_o &&
    off_cnt < code_gap_i) else $error("lamp dark too long");
  a_code_digits: assert property (fault_any_o |->
    code_hi_o == 3'(fault_idx_o / 5 + 1) && code_lo_o == 3'(fault_idx_o % 5 + 1))
    else $error("wrong digits for shown fault");
  a_shown_active: assert property (fault_any_o |->
    active_o[fault_idx_o] || prev_act[fault_idx_o]) else $error("shown idle");
  a_fault_shown: assert property (up && active_o != '0 |->
    ##[0:1] fault_any_o) else $error("active fault not shown");
  a_cond_reported: assert property (up |-> (prev_cond & ~active_o) == '0)
    else $error("condition not reported");
  a_transient_drop: assert property (up |-> (active_o & ~prev_cond &
    ~(KEYM | 20'h20000)) == '0) else $error("transient fault kept");
  // A key edge shows as a drop two samples later
  a_key_latch: assert property (up && !$rose(key_on_i) |=> ##1
    (prev_act & ~active_o & KEYM) == '0) else $error("latched fault lost");
  a_nvm_hold: assert property (up && !$rose(key_on_i) |=> ##1
    !(prev_act[17] && !active_o[17])) else $error("checksum fault lost");
  a_disable_resp: assert property (up && (prev_cond & DISM) != '0 |->
    ##[0:1] response_o == 2'h3) else $error("drive not disabled");
  a_pulse_len: assert property (s_pulse_end |-> on_cnt == pulse_on_i)
    else $error("pulse length wrong");
  a_gap_len: assert property (s_lamp_back |-> off_cnt == pulse_off_i ||
    off_cnt == digit_gap_i || off_cnt == code_gap_i) else $error("bad gap");
endmodule // flsq_seq_checker

/* bench/flsq_lamp_reader.sv */
/* Status lamp reader: decodes blink codes seen on the lamp line.
   Assumes off, digit and code gaps of distinct lengths. */
`timescale 1ns/100ps
module flsq_lamp_reader (
  input wire ref_clk_i, // clock
  input wire rst_i, // reset
  input wire lamp_i, // lamp line
  input wire [31:0] t_on_i, // pulse on
  input wire [31:0] t_dg_i, // digit gap
  input wire [31:0] t_cg_i, // code gap
  output reg [2:0] code_hi_o, // digit one
  output reg [2:0] code_lo_o, // digit two
  output reg [7:0] n_codes_o // codes seen
);
  reg [31:0] on_run;
  reg [31:0] off_run;
  reg [2:0] cnt;
  reg prev;
  reg sync;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_run <= 32'h0;
      off_run <= 32'h0;
      cnt <= 3'h0;
      prev <= 1'b0;
      sync <= 1'b0;
      code_hi_o <= 3'h0;
      code_lo_o <= 3'h0;
      n_codes_o <= 8'h0;
    end else begin
      prev <= lamp_i;
      if (lamp_i) begin
        on_run <= on_run + 32'h1;
        off_run <= 32'h0;
        if (!prev && off_run == t_dg_i) begin
          code_hi_o <= cnt;
          cnt <= 3'h0;
        end
        if (!prev && off_run == t_cg_i) begin
          code_lo_o <= cnt;
          cnt <= 3'h0;
          sync <= 1'b1;
          n_codes_o <= n_codes_o + {7'h0, sync};
        end
        if (on_run > t_on_i) begin
          sync <= 1'b0;
          cnt <= 3'h0;
        end
      end else begin
        off_run <= off_run + 32'h1;
        on_run <= 32'h0;
        if (prev)
          cnt <= cnt + 3'h1;
      end
    end
  end
endmodule // flsq_lamp_reader

/* bench/flsq_seq_tb.sv */
/* Self-checking bench for the fault code lamp sequencer.
   Assumes the core files and the checker and lamp reader are compiled. */
`timescale 1ns/100ps
module flsq_seq_tb;
  localparam [19:0] KEYM = 20'h99480;
  localparam [11:0] ROWS [0:19] = '{12'h111, 12'h212, 12'h213, 12'h114,
    12'h115, 12'h321, 12'h222, 12'h323, 12'h324, 12'h225, 12'h331, 12'h332,
    12'h333, 12'h334, 12'h335, 12'h341, 12'h342, 12'h343, 12'h244, 12'h345};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg key = 1'b1;
  reg chg = 1'b0;
  reg hclr = 1'b0;
  reg ovr = 1'b0;
  reg [19:0] cond = 20'h0;
  reg [4:0] haddr = 5'h0;
  reg [99:0] rank = {20{5'h1F}};
  reg [31:0] ton = 32'h2;
  reg [31:0] toff = 32'h2;
  reg [31:0] tdg = 32'h3;
  reg [31:0] tcg = 32'h4;
  wire lamp, any, hrd;
  wire [4:0] idx;
  wire [2:0] hi, lo, p_hi, p_lo;
  wire [19:0] act, hall;
  wire [1:0] resp;
  wire [7:0] ncode;
  integer n_errors = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer i;
  always #2 clk = ~clk;
  flsq_seq uut (.ref_clk_i(clk), .rst_i(rst), .fault_cond_i(cond),
    .key_on_i(key), .param_changed_i(chg), .hist_clear_i(hclr),
    .hist_addr_i(haddr), .rank_override_i(ovr), .rank_tbl_i(rank),
    .pulse_on_i(ton), .pulse_off_i(toff), .digit_gap_i(tdg),
    .code_gap_i(tcg), .lamp_o(lamp), .fault_any_o(any),
    .fault_idx_o(idx), .code_hi_o(hi), .code_lo_o(lo), .active_o(act),
    .response_o(resp), .hist_rd_o(hrd), .hist_all_o(hall));
  flsq_lamp_reader rdr (.ref_clk_i(clk), .rst_i(rst), .lamp_i(lamp),
    .t_on_i(ton), .t_dg_i(tdg), .t_cg_i(tcg), .code_hi_o(p_hi),
    .code_lo_o(p_lo), .n_codes_o(ncode));
  ////////////////////////////////////////////////////////////////////////
  task check(input string name, input [31:0] seen, input [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Two codes: the first after a switch may be partial
  task wait_code;
    reg [7:0] n0;
    integer k;
    begin
      n0 = ncode;
      k = 0;
      while (ncode != n0 + 8'h02 && k < 400) begin
        @(posedge clk);
        k = k + 1;
      end
      check("code wait", k < 400, 1);
      @(negedge clk);
    end
  endtask
  task key_cycle;
    key = 1'b0;
    repeat (3) @(negedge clk);
    key = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    check("lamp in reset", lamp, 0);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("lamp steady", lamp, 1);
    check("fault shown", any, 0);
    $display("test reset done");
    for (i = 0; i < 20; i = i + 1) begin
      cond = 20'h1 << i;
      wait_code;
      check("shown index", idx, i);
      check("blinked", {1'b0, p_hi, 1'b0, p_lo}, ROWS[i][7:0]);
      check("digits", {1'b0, hi, 1'b0, lo}, ROWS[i][7:0]);
      check("response", resp, ROWS[i][9:8]);
      check("history", hall[i], 1);
      cond = 20'h0;
      repeat (3) @(negedge clk);
      check("held", act[i], KEYM[i] | (i == 17));
      if (i == 17) begin
        key_cycle;
        check("checksum held", act[i], 1);
        chg = 1'b1;
        @(negedge clk);
        chg = 1'b0;
      end
      if (act[i])
        key_cycle;
      check("cleared", act[i], 0);
      check("steady again", lamp, 1);
      $display("test fault %0d done", i);
    end
    cond = 20'h00202;
    wait_code;
    check("top index", idx, 1);
    // Table lifts fault 9 above fault 1
    ovr = 1'b1;
    rank[45 +: 5] = 5'h00;
    wait_code;
    check("ranked index", idx, 9);
    ovr = 1'b0;
    wait_code;
    check("fixed order", idx, 1);
    cond = 20'h00200;
    wait_code;
    check("next code", {1'b0, p_hi, 1'b0, p_lo}, 8'h25);
    cond = 20'h0;
    $display("test priority done");
    haddr = 5'h09;
    repeat (3) @(negedge clk);
    check("entry set", hrd, 1);
    // Onset in the clearing cycle must survive the clear
    hclr = 1'b1;
    cond = 20'h00001;
    @(negedge clk);
    hclr = 1'b0;
    cond = 20'h0;
    repeat (3) @(negedge clk);
    check("list after clear", hall, 20'h00001);
    check("entry clear", hrd, 0);
    haddr = 5'h14;
    repeat (3) @(negedge clk);
    check("past end", hrd, 0);
    $display("test history done");
    // Longer timings, changed while steady
    ton = 32'h3;
    tdg = 32'h5;
    tcg = 32'h7;
    cond = 20'h00008;
    wait_code;
    check("slow code", {1'b0, p_hi, 1'b0, p_lo}, 8'h14);
    $display("test timing done");
    repeat (5) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    check("lamp in reset", lamp, 0);
    cond = 20'h0;
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("lamp after reset", lamp, 1);
    $display("test second reset done");
    report_and_stop;
  end
endmodule // flsq_seq_tb
bind flsq_seq flsq_seq_checker #(.N(N), .AW(AW), .RW(RW), .TW(TW)) chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .fault_cond_i(fault_cond_i),
  .key_on_i(key_on_i), .param_changed_i(param_changed_i),
  .hist_clear_i(hist_clear_i), .hist_addr_i(hist_addr_i),
  .rank_override_i(rank_override_i), .rank_tbl_i(rank_tbl_i),
  .pulse_on_i(pulse_on_i), .pulse_off_i(pulse_off_i),
  .digit_gap_i(digit_gap_i), .code_gap_i(code_gap_i), .lamp_o(lamp_o),
  .fault_any_o(fault_any_o), .fault_idx_o(fault_idx_o),
  .code_hi_o(code_hi_o), .code_lo_o(code_lo_o), .active_o(active_o),
  .response_o(response_o), .hist_rd_o(hist_rd_o), .hist_all_o(hist_all_o));
